/* rtl/pwv_rearm.sv */
/*
 * Rearm delay timer: blocks further triggers for a loaded cycle count.
 * Assumes start_i is a one-cycle pulse on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
module pwv_rearm (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   // Control
   input  wire logic        start_i,
   input  wire logic [31:0] load_i,
   // Status
   output logic             busy_o
);
   // ==========================================================
   logic [31:0] cnt_q;
   logic [31:0] cnt_d;
   // Count down from the load value; zero means armed
   always_comb begin
      cnt_d = cnt_q;
      if (start_i) begin
         cnt_d = load_i;
      end else if (cnt_q != 32'h00000000) begin
         cnt_d = cnt_q - 32'h00000001;
      end
   end
   // Registers
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         cnt_q <= 32'h00000000;
      end else begin
         cnt_q <= cnt_d;
      end
   end
   assign busy_o = (cnt_q != 32'h00000000);
endmodule // pwv_rearm
`default_nettype wire

/* rtl/pwv_sync.sv */
/*
 * Two-flop synchroniser, one per bit.
 * Assumes inputs arrive from pins asynchronous to the clock.
 */
`timescale 1ns/10ps
`default_nettype none
module pwv_sync #(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         srst_i,
   // Data
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   // ==========================================================
   // Per-bit stages; first stage feeds only the second
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         logic meta_q;
         logic meta_d;
         logic out_q;
         logic out_d;
         // Next values
         always_comb begin
            meta_d = async_i[g];
            out_d  = meta_q;
         end
         // Registers
         always_ff @(posedge clk_i) begin
            if (srst_i) begin
               meta_q <= 1'b0;
               out_q  <= 1'b0;
            end else begin
               meta_q <= meta_d;
               out_q  <= out_d;
            end
         end
         assign sync_o[g] = out_q;
      end
   endgenerate
endmodule // pwv_sync
`default_nettype wire

/* rtl/pwv_top.sv */
/*
 * Pulse-width violation trigger with an AXI4-Lite register slave.
 * Assumes ADC sample codes arrive on REF_CLK_I; digital inputs are
 * asynchronous pins and are synchronised here.
 */
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
// Notes on behaviour
// - positive pulse fires at falling level crossing
// - negative pulse fires at rising level crossing
// - direction picks wider-than or narrower-than pulses
// - width held within 1.5 ns to 10 s; the code's lower bound is WIDTH_MIN_CYC, one 4 ns clock cycle
// - analog source index 1-4, or 1-2
// - digital inputs 0-15 selectable when option present
// - external source only on two-channel variant
// - pulse counts only after crossing the level
// - every setting reads back as in effect
// - rearm delay and noise reject condition trigger
// - only the width violation type drives trigger
`timescale 1ns/10ps
`default_nettype none
module pwv_top #(
   parameter int          NUM_ANALOG    = 4,
   parameter bit          HAS_DIGITAL   = 1'b1,
   parameter logic [31:0] WIDTH_MAX_CYC = 32'(pwv_pkg::WIDTH_MAX_CYC_DFLT)
) (
   // Clock and reset
   input  wire logic            REF_CLK_I,
   input  wire logic            SRST_I,
   // Signal under test
   input  wire logic [3:0][7:0] ANA_SAMPLE_I,
   input  wire logic [7:0]      EXT_SAMPLE_I,
   input  wire logic [15:0]     DIG_I,
   // Trigger
   output logic                 TRIG_O,
   // AXI4-Lite write
   input  wire logic [7:0]      S_AXI_AWADDR_I,
   input  wire logic            S_AXI_AWVALID_I,
   output logic                 S_AXI_AWREADY_O,
   input  wire logic [31:0]     S_AXI_WDATA_I,
   input  wire logic [3:0]      S_AXI_WSTRB_I,
   input  wire logic            S_AXI_WVALID_I,
   output logic                 S_AXI_WREADY_O,
   output logic [1:0]           S_AXI_BRESP_O,
   output logic                 S_AXI_BVALID_O,
   input  wire logic            S_AXI_BREADY_I,
   // AXI4-Lite read
   input  wire logic [7:0]      S_AXI_ARADDR_I,
   input  wire logic            S_AXI_ARVALID_I,
   output logic                 S_AXI_ARREADY_O,
   output logic [31:0]          S_AXI_RDATA_O,
   output logic [1:0]           S_AXI_RRESP_O,
   output logic                 S_AXI_RVALID_O,
   input  wire logic            S_AXI_RREADY_I
);
   // ==========================================================
   // Declarations
   logic        en_q, en_d, pol_q, pol_d, dir_q, dir_d;
   logic [1:0]  vt_q, vt_d;
   logic [4:0]  src_q, src_d;
   logic [31:0] width_q, width_d, rearm_q, rearm_d;
   logic [7:0]  level_q, level_d, reject_q, reject_d;
   logic        awrdy_q, awrdy_d, wrdy_q, wrdy_d, bvld_q, bvld_d;
   logic        aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
   logic [7:0]  awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0]  wstrb_q, wstrb_d;
   logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
   logic        ardy_q, ardy_d, rvld_q, rvld_d;
   logic [31:0] rdata_q, rdata_d;
   logic [15:0] dig_s;
   logic [7:0]  sample;
   logic        dig_sel;
   logic        above_q, above_d, act_prev_q, act_prev_d;
   logic        seen_q, seen_d, trig_q, trig_d;
   logic [31:0] cnt_q, cnt_d, last_q, last_d;
   logic [15:0] ntrig_q, ntrig_d;
   logic        active, lead, trail, busy, fire, viol;
   logic [7:0]  lo_thr;

   // ==========================================================
   // Helpers
   function automatic logic src_ok(input logic [4:0] s);
      logic ok;
      ok = 1'b0;
      if (s < 5'(pwv_pkg::NUM_DIGITAL)) begin
         ok = HAS_DIGITAL;
      end else if (s == pwv_pkg::SRC_EXTERNAL) begin
         ok = (NUM_ANALOG == 2);
      end else if (s > pwv_pkg::SRC_ANALOG_BASE) begin
         ok = (s <= pwv_pkg::SRC_ANALOG_BASE + 5'(NUM_ANALOG));
      end
      return ok;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  st);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (st[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // ==========================================================
   // Digital inputs come from pins
   pwv_sync #(.W(16)) u_sync (
      .clk_i   (REF_CLK_I),
      .srst_i  (SRST_I),
      .async_i (DIG_I),
      .sync_o  (dig_s)
   );

   // Rearm delay holds off triggers after each fire
   pwv_rearm u_rearm (
      .clk_i   (REF_CLK_I),
      .srst_i  (SRST_I),
      .start_i (trig_q),
      .load_i  (rearm_q),
      .busy_o  (busy)
   );

   // ==========================================================
   // Write channel: address and data taken in either order
   always_comb begin
      logic [31:0] m;
      m         = 32'h00000000;
      awrdy_d   = awrdy_q;
      wrdy_d    = wrdy_q;
      bvld_d    = bvld_q;
      bresp_d   = bresp_q;
      aw_hold_d = aw_hold_q;
      w_hold_d  = w_hold_q;
      awaddr_d  = awaddr_q;
      wdata_d   = wdata_q;
      wstrb_d   = wstrb_q;
      en_d      = en_q;
      pol_d     = pol_q;
      dir_d     = dir_q;
      vt_d      = vt_q;
      src_d     = src_q;
      width_d   = width_q;
      level_d   = level_q;
      reject_d  = reject_q;
      rearm_d   = rearm_q;
      if (S_AXI_AWVALID_I && awrdy_q) begin
         awaddr_d  = S_AXI_AWADDR_I;
         aw_hold_d = 1'b1;
         awrdy_d   = 1'b0;
      end
      if (S_AXI_WVALID_I && wrdy_q) begin
         wdata_d  = S_AXI_WDATA_I;
         wstrb_d  = S_AXI_WSTRB_I;
         w_hold_d = 1'b1;
         wrdy_d   = 1'b0;
      end
      if (aw_hold_q && w_hold_q && !bvld_q) begin
         aw_hold_d = 1'b0;
         w_hold_d  = 1'b0;
         bvld_d    = 1'b1;
         bresp_d   = pwv_pkg::AXI_OKAY;
         case (awaddr_q)
            pwv_pkg::OFS_CTRL: begin
               m     = merge({26'h0, vt_q, 1'b0, dir_q, pol_q, en_q},
                             wdata_q, wstrb_q);
               en_d  = m[pwv_pkg::CTRL_EN_BIT];
               pol_d = m[pwv_pkg::CTRL_POL_BIT];
               dir_d = m[pwv_pkg::CTRL_DIR_BIT];
               // Unknown type code is ignored
               if (m[pwv_pkg::CTRL_VT_LSB +: 2] != 2'h3) begin
                  vt_d = m[pwv_pkg::CTRL_VT_LSB +: 2];
               end
            end
            pwv_pkg::OFS_SOURCE: begin
               m = merge({27'h0, src_q}, wdata_q, wstrb_q);
               // Illegal source for this variant leaves the old one
               if (m[31:5] == 27'h0 && src_ok(m[4:0])) begin
                  src_d = m[4:0];
               end
            end
            pwv_pkg::OFS_WIDTH: begin
               m = merge(width_q, wdata_q, wstrb_q);
               // Clamp so the setting in effect stays in span
               if (m < pwv_pkg::WIDTH_MIN_CYC) begin
                  width_d = pwv_pkg::WIDTH_MIN_CYC;
               end else if (m > WIDTH_MAX_CYC) begin
                  width_d = WIDTH_MAX_CYC;
               end else begin
                  width_d = m;
               end
            end
            pwv_pkg::OFS_LEVEL: begin
               m        = merge({16'h0, reject_q, level_q},
                                wdata_q, wstrb_q);
               level_d  = m[pwv_pkg::LEVEL_LSB +: 8];
               reject_d = m[pwv_pkg::REJECT_LSB +: 8];
            end
            pwv_pkg::OFS_REARM: begin
               rearm_d = merge(rearm_q, wdata_q, wstrb_q);
            end
            default: begin
               bresp_d = pwv_pkg::AXI_SLVERR;
            end
         endcase
      end
      if (bvld_q && S_AXI_BREADY_I) begin
         bvld_d  = 1'b0;
         awrdy_d = 1'b1;
         wrdy_d  = 1'b1;
      end
   end

   // ==========================================================
   // Read channel: one read in flight, answer one cycle later
   always_comb begin
      ardy_d  = ardy_q;
      rvld_d  = rvld_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (S_AXI_ARVALID_I && ardy_q) begin
         ardy_d  = 1'b0;
         rvld_d  = 1'b1;
         rresp_d = pwv_pkg::AXI_OKAY;
         case (S_AXI_ARADDR_I)
            pwv_pkg::OFS_CTRL:   rdata_d = {26'h0, vt_q, 1'b0, dir_q,
                                            pol_q, en_q};
            pwv_pkg::OFS_SOURCE: rdata_d = {27'h0, src_q};
            pwv_pkg::OFS_WIDTH:  rdata_d = width_q;
            pwv_pkg::OFS_LEVEL:  rdata_d = {16'h0, reject_q, level_q};
            pwv_pkg::OFS_REARM:  rdata_d = rearm_q;
            pwv_pkg::OFS_STATUS: rdata_d = {ntrig_q, 13'h0, busy,
                                            act_prev_q, above_q};
            pwv_pkg::OFS_LAST:   rdata_d = last_q;
            default: begin
               rdata_d = 32'h00000000;
               rresp_d = pwv_pkg::AXI_SLVERR;
            end
         endcase
      end else if (rvld_q && S_AXI_RREADY_I) begin
         rvld_d = 1'b0;
         ardy_d = 1'b1;
      end
   end

   // ==========================================================
   // Source select and level comparison with noise reject band
   always_comb begin
      dig_sel = 1'b0;
      sample  = 8'h00;
      if (src_q < 5'(pwv_pkg::NUM_DIGITAL)) begin
         dig_sel = dig_s[src_q[3:0]];
      end else if (src_q == pwv_pkg::SRC_EXTERNAL) begin
         sample = EXT_SAMPLE_I;
      end else begin
         sample = ANA_SAMPLE_I[2'(src_q - pwv_pkg::SRC_ANALOG_BASE
                                  - 5'h01)];
      end
      lo_thr = (level_q > reject_q) ? level_q - reject_q : 8'h00;
      // Falls only below the band so noise near level is ignored
      if (src_q < 5'(pwv_pkg::NUM_DIGITAL)) begin
         above_d = dig_sel;
      end else if (above_q) begin
         above_d = (sample >= lo_thr);
      end else begin
         above_d = (sample >= level_q);
      end
   end

   // ==========================================================
   // Pulse measurement and trigger decision
   assign active = pol_q ? above_q : !above_q;
   assign lead   = active && !act_prev_q;
   assign trail  = !active && act_prev_q;
   assign viol   = dir_q ? (cnt_q > width_q) : (cnt_q < width_q);
   assign fire   = trail && seen_q && viol && en_q && !busy
                   && (vt_q == pwv_pkg::VT_WIDTH);

   always_comb begin
      act_prev_d = active;
      seen_d     = seen_q;
      cnt_d      = cnt_q;
      last_d     = last_q;
      ntrig_d    = ntrig_q;
      trig_d     = fire;
      if (lead) begin
         seen_d = 1'b1;
         cnt_d  = 32'h00000001;
      end else if (active && cnt_q != 32'hffffffff) begin
         cnt_d = cnt_q + 32'h00000001;
      end
      if (trail && seen_q) begin
         last_d = cnt_q;
      end
      if (fire) begin
         ntrig_d = ntrig_q + 16'h0001;
      end
      // A new source must be crossed again before it counts
      if (src_d != src_q) begin
         seen_d = 1'b0;
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         en_q       <= 1'b0;
         pol_q      <= 1'b1;
         dir_q      <= 1'b1;
         vt_q       <= pwv_pkg::VT_WIDTH;
         src_q      <= pwv_pkg::SRC_RST;
         width_q    <= pwv_pkg::WIDTH_MIN_CYC;
         level_q    <= pwv_pkg::LEVEL_RST;
         reject_q   <= pwv_pkg::REJECT_RST;
         rearm_q    <= pwv_pkg::REARM_RST;
         awrdy_q    <= 1'b0;
         wrdy_q     <= 1'b0;
         bvld_q     <= 1'b0;
         bresp_q    <= pwv_pkg::AXI_OKAY;
         aw_hold_q  <= 1'b0;
         w_hold_q   <= 1'b0;
         awaddr_q   <= 8'h00;
         wdata_q    <= 32'h00000000;
         wstrb_q    <= 4'h0;
         ardy_q     <= 1'b0;
         rvld_q     <= 1'b0;
         rdata_q    <= 32'h00000000;
         rresp_q    <= pwv_pkg::AXI_OKAY;
         above_q    <= 1'b0;
         act_prev_q <= 1'b0;
         seen_q     <= 1'b0;
         trig_q     <= 1'b0;
         cnt_q      <= 32'h00000000;
         last_q     <= 32'h00000000;
         ntrig_q    <= 16'h0000;
      end else begin
         en_q       <= en_d;
         pol_q      <= pol_d;
         dir_q      <= dir_d;
         vt_q       <= vt_d;
         src_q      <= src_d;
         width_q    <= width_d;
         level_q    <= level_d;
         reject_q   <= reject_d;
         rearm_q    <= rearm_d;
         // Ready rises once after reset, then follows handshakes
         awrdy_q    <= awrdy_d || (!awrdy_q && !aw_hold_q && !bvld_q
                                   && !wrdy_q && !w_hold_q);
         wrdy_q     <= wrdy_d || (!awrdy_q && !aw_hold_q && !bvld_q
                                  && !wrdy_q && !w_hold_q);
         bvld_q     <= bvld_d;
         bresp_q    <= bresp_d;
         aw_hold_q  <= aw_hold_d;
         w_hold_q   <= w_hold_d;
         awaddr_q   <= awaddr_d;
         wdata_q    <= wdata_d;
         wstrb_q    <= wstrb_d;
         ardy_q     <= ardy_d || (!ardy_q && !rvld_q);
         rvld_q     <= rvld_d;
         rdata_q    <= rdata_d;
         rresp_q    <= rresp_d;
         above_q    <= above_d;
         act_prev_q <= act_prev_d;
         seen_q     <= seen_d;
         trig_q     <= trig_d;
         cnt_q      <= cnt_d;
         last_q     <= last_d;
         ntrig_q    <= ntrig_d;
      end
   end

   // Outputs straight from flops
   assign TRIG_O          = trig_q;
   assign S_AXI_AWREADY_O = awrdy_q;
   assign S_AXI_WREADY_O  = wrdy_q;
   assign S_AXI_BVALID_O  = bvld_q;
   assign S_AXI_BRESP_O   = bresp_q;
   assign S_AXI_ARREADY_O = ardy_q;
   assign S_AXI_RVALID_O  = rvld_q;
   assign S_AXI_RDATA_O   = rdata_q;
   assign S_AXI_RRESP_O   = rresp_q;

   // ==========================================================
   // Checks
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (SRST_I);

   chk_pos_falling: assert property (
      trig_q && $past(pol_q) |-> $past(act_prev_q) && !$past(above_q))
      else $error("positive trigger not at falling crossing");
   chk_neg_rising: assert property (
      trig_q && !$past(pol_q) |-> $past(act_prev_q) && $past(above_q))
      else $error("negative trigger not at rising crossing");
   chk_wider_only: assert property (
      trig_q && $past(dir_q) |-> $past(cnt_q) > $past(width_q))
      else $error("wider trigger on short pulse");
   chk_narrower_only: assert property (
      trig_q && !$past(dir_q) |-> $past(cnt_q) < $past(width_q))
      else $error("narrower trigger on long pulse");
   chk_width_span: assert property (
      width_q >= pwv_pkg::WIDTH_MIN_CYC && width_q <= WIDTH_MAX_CYC)
      else $error("width outside span");
   chk_source_legal: assert property (
      src_ok(src_q))
      else $error("illegal source in effect");
   chk_level_seen: assert property (
      trig_q |-> $past(seen_q))
      else $error("trigger before level crossing");
   chk_width_readback: assert property (
      S_AXI_ARVALID_I && ardy_q && S_AXI_ARADDR_I == pwv_pkg::OFS_WIDTH
      |=> rvld_q && rdata_q == $past(width_q))
      else $error("width read back wrong");
   chk_rearm_holds: assert property (
      trig_q && rearm_q != 32'h00000000 |=> !trig_q [*2])
      else $error("trigger during rearm delay");
   chk_type_gate: assert property (
      trig_q |-> $past(vt_q) == pwv_pkg::VT_WIDTH)
      else $error("trigger from other violation type");
   chk_count_start: assert property (
      lead |=> cnt_q == 32'h00000001)
      else $error("count not restarted at leading edge");

   cov_wider: cover property (trig_q && dir_q);
   cov_narrower: cover property (trig_q && !dir_q);
   cov_rearm_block: cover property (trail && viol && en_q && busy);
   cov_write: cover property (bvld_q && S_AXI_BREADY_I);
endmodule // pwv_top
`default_nettype wire

/* shared/pwv_pkg.sv */
/*
 * Constants for the pulse-width violation trigger: register offsets,
 * field positions, reset values, source codes and timing figures.
 * Assumes a 250 MHz reference clock and 8-bit sample codes.
 */
`default_nettype none
package pwv_pkg;
   // ==========================================================
   // Timing
   localparam int unsigned  CLK_PERIOD_PS  = 4000;
   localparam int unsigned  WIDTH_MIN_PS   = 1500;
   localparam longint       WIDTH_MAX_S    = 10;
   localparam logic [31:0]  WIDTH_MIN_CYC  =
      32'((WIDTH_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam longint       WIDTH_MAX_CYC_DFLT =
      (WIDTH_MAX_S * 64'd1000000000000) / CLK_PERIOD_PS;
   // ==========================================================
   // Register byte offsets
   localparam logic [7:0]   OFS_CTRL       = 8'h00;
   localparam logic [7:0]   OFS_SOURCE     = 8'h04;
   localparam logic [7:0]   OFS_WIDTH      = 8'h08;
   localparam logic [7:0]   OFS_LEVEL      = 8'h0c;
   localparam logic [7:0]   OFS_REARM      = 8'h10;
   localparam logic [7:0]   OFS_STATUS     = 8'h14;
   localparam logic [7:0]   OFS_LAST       = 8'h18;
   // ==========================================================
   // Field positions
   localparam int           CTRL_EN_BIT    = 0;
   localparam int           CTRL_POL_BIT   = 1;
   localparam int           CTRL_DIR_BIT   = 2;
   localparam int           CTRL_VT_LSB    = 4;
   localparam int           LEVEL_LSB      = 0;
   localparam int           REJECT_LSB     = 8;
   localparam int           STAT_ABOVE_BIT = 0;
   localparam int           STAT_PULSE_BIT = 1;
   localparam int           STAT_BUSY_BIT  = 2;
   localparam int           STAT_CNT_LSB   = 16;
   // ==========================================================
   // Source codes
   localparam logic [4:0]   SRC_ANALOG_BASE = 5'h10;
   localparam logic [4:0]   SRC_EXTERNAL    = 5'h1f;
   localparam int unsigned  NUM_DIGITAL     = 16;
   // ==========================================================
   // Reset values
   localparam logic [4:0]   SRC_RST        = 5'h11;
   localparam logic [7:0]   LEVEL_RST      = 8'h80;
   localparam logic [7:0]   REJECT_RST     = 8'h00;
   localparam logic [31:0]  REARM_RST      = 32'h00000000;
   localparam logic [1:0]   AXI_OKAY       = 2'h0;
   localparam logic [1:0]   AXI_SLVERR     = 2'h2;
   // ==========================================================
   // Violation types
   typedef enum logic [1:0] {
      VT_WIDTH      = 2'h0,
      VT_SETUP_HOLD = 2'h1,
      VT_TRANSITION = 2'h2
   } pwv_vtype_t;
endpackage
`default_nettype wire

/* verif/pwv_src.sv */
/* Waveform source model: one pulse on every source input at once.
   Assumes go_i is a one-cycle pulse on clk_i. */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Source model
module pwv_src (
   // Control
   input  wire logic       clk_i,
   input  wire logic       go_i,
   input  wire logic [7:0] len_i,
   input  wire logic       pos_i,
   // Signal under test
   output logic [3:0][7:0] ana_o,
   output logic [7:0]      ext_o,
   output logic [15:0]     dig_o
);
   logic [7:0] left_q = 8'h00;
   logic       hi;
   // Countdown of the active samples
   always_ff @(posedge clk_i) begin
      if (go_i) left_q <= len_i;
      else if (left_q != 8'h00) left_q <= left_q - 8'h01;
   end
   // Codes sit well clear of the default level on both sides
   assign hi = (left_q != 8'h00) ~^ pos_i;
   assign ana_o = {4{hi ? 8'hc0 : 8'h20}};
   assign ext_o = hi ? 8'hc0 : 8'h20;
   assign dig_o = {16{hi}};
endmodule // pwv_src
`default_nettype wire

/* verif/tb.sv */
/* Testbench: AXI4-Lite master tasks and pulse scenarios.
   Assumes pwv_pkg is compiled first and the source model beside it. */
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic clk = 1'b0, rst = 1'b1, go = 1'b0, pos = 1'b1;
   logic aw_v = 1'b0, w_v = 1'b0, ar_v = 1'b0;
   logic awr, wrdy, bv, arr, rv, trig;
   logic [7:0] len = 8'h00, aw_a = 8'h00, ar_a = 8'h00, ext;
   logic [31:0] wd = 32'h0, rd_v, rdata;
   logic [1:0] resp, bresp, rresp;
   logic [3:0][7:0] ana;
   logic [15:0] dig;
   int err_count = 0, total_checks = 0, trigs;
   // ==========================================================
   // Design and source; response readies stay high throughout
   pwv_src src (.clk_i(clk), .go_i(go), .len_i(len), .pos_i(pos),
      .ana_o(ana), .ext_o(ext), .dig_o(dig));
   pwv_top #(.WIDTH_MAX_CYC(32'h40)) uut (.REF_CLK_I(clk), .SRST_I(rst),
      .ANA_SAMPLE_I(ana), .EXT_SAMPLE_I(ext), .DIG_I(dig), .TRIG_O(trig),
      .S_AXI_AWADDR_I(aw_a), .S_AXI_AWVALID_I(aw_v),
      .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf),
      .S_AXI_WVALID_I(w_v), .S_AXI_WREADY_O(wrdy), .S_AXI_BRESP_O(bresp),
      .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(1'b1), .S_AXI_ARADDR_I(ar_a),
      .S_AXI_ARVALID_I(ar_v), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata),
      .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(1'b1));
   initial forever #2 clk = ~clk;
   // ==========================================================
   // Shared tasks
   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      aw_a <= a;
      wd <= d;
      aw_v <= 1'b1;
      w_v <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (awr) aw_v <= 1'b0;
         if (wrdy) w_v <= 1'b0;
         if (bv) break;
      end
      resp = bresp;
      if (n == 40) begin
         err_count++;
         wrap_up();
      end
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      ar_a <= a;
      ar_v <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (arr) ar_v <= 1'b0;
         if (rv) break;
      end
      rd_v = rdata;
      resp = rresp;
      if (n == 40) begin
         err_count++;
         wrap_up();
      end
   endtask
   // Window covers the digital path's extra sync stages
   task automatic pulse(input logic [7:0] l);
      trigs = 0;
      len <= l;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (30) begin
         @(posedge clk);
         if (trig === 1'b1) trigs++;
      end
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset();
      rd(pwv_pkg::OFS_CTRL);
      chk("ctrl", rd_v, 32'h6);
      rd(pwv_pkg::OFS_SOURCE);
      chk("source", rd_v, 32'h11);
      rd(pwv_pkg::OFS_LEVEL);
      chk("level", rd_v, 32'h80);
      $display("reset values done");
   endtask
   task automatic t_wider();
      wr(pwv_pkg::OFS_CTRL, 32'h7);
      wr(pwv_pkg::OFS_WIDTH, 32'h2);
      pulse(8'h03);
      chk("wide trig", trigs, 32'h1);
      pulse(8'h02);
      chk("equal trig", trigs, 32'h0);
      rd(pwv_pkg::OFS_LAST);
      chk("last", rd_v, 32'h2);
      wr(pwv_pkg::OFS_LEVEL, 32'hd0);
      pulse(8'h03);
      chk("level trig", trigs, 32'h0);
      wr(pwv_pkg::OFS_LEVEL, 32'h80);
      wr(pwv_pkg::OFS_REARM, 32'h3c);
      pulse(8'h03);
      pulse(8'h03);
      chk("rearm trig", trigs, 32'h0);
      wr(pwv_pkg::OFS_REARM, 32'h0);
      repeat (60) @(posedge clk);
      $display("wider done");
   endtask
   task automatic t_src();
      wr(pwv_pkg::OFS_SOURCE, 32'h5);
      pulse(8'h03);
      chk("digital trig", trigs, 32'h1);
      wr(pwv_pkg::OFS_SOURCE, 32'h14);
      pulse(8'h03);
      chk("analog4 trig", trigs, 32'h1);
      wr(pwv_pkg::OFS_SOURCE, 32'h1f);
      wr(pwv_pkg::OFS_SOURCE, 32'h10);
      rd(pwv_pkg::OFS_SOURCE);
      chk("source kept", rd_v, 32'h14);
      $display("source done");
   endtask
   task automatic t_narrow();
      wr(pwv_pkg::OFS_WIDTH, 32'h4);
      wr(pwv_pkg::OFS_CTRL, 32'h3);
      pulse(8'h02);
      chk("narrow trig", trigs, 32'h1);
      pulse(8'h05);
      chk("wide no trig", trigs, 32'h0);
      pos <= 1'b0;
      repeat (8) @(posedge clk);
      wr(pwv_pkg::OFS_CTRL, 32'h1);
      pulse(8'h02);
      chk("negative trig", trigs, 32'h1);
      wr(pwv_pkg::OFS_CTRL, 32'h11);
      pulse(8'h02);
      chk("setup type", trigs, 32'h0);
      wr(pwv_pkg::OFS_CTRL, 32'h31);
      rd(pwv_pkg::OFS_CTRL);
      chk("type kept", rd_v, 32'h11);
      $display("narrow done");
   endtask
   task automatic t_map();
      wr(pwv_pkg::OFS_WIDTH, 32'h0);
      rd(pwv_pkg::OFS_WIDTH);
      chk("width min", rd_v, 32'h1);
      wr(pwv_pkg::OFS_WIDTH, 32'hffffffff);
      rd(pwv_pkg::OFS_WIDTH);
      chk("width max", rd_v, 32'h40);
      wr(8'h40, 32'h1);
      chk("bad wr", resp, pwv_pkg::AXI_SLVERR);
      rd(8'h40);
      chk("bad rd", resp, pwv_pkg::AXI_SLVERR);
      $display("map done");
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_wider();
      t_src();
      t_narrow();
      t_map();
      wrap_up();
   end
endmodule // tb
`default_nettype wire
